// >>> design/rcf_map.svh
`ifndef RCF_MAP_SVH
`define RCF_MAP_SVH

// Register addresses on the serial register port.
`define RCF_ADDR_OPTIONS      4'hD
`define RCF_ADDR_FLAGS        4'hE
`define RCF_ADDR_CONTROL      4'hF

// Option register fields.
`define RCF_OPT_TEST_BIT      7
`define RCF_OPT_ALARM_SEL_BIT 6
`define RCF_OPT_UPD_SEL_BIT   5
`define RCF_OPT_CNT_EN_BIT    4
`define RCF_OPT_SRC_HI_BIT    1
`define RCF_OPT_SRC_LO_BIT    0
`define RCF_OPT_RESET_VAL     8'h00
`define RCF_OPT_RW_MASK       8'hF3

// Flag register fields.
`define RCF_FLG_UPDATE_BIT    5
`define RCF_FLG_TIMER_BIT     4
`define RCF_FLG_ALARM_BIT     3
`define RCF_FLG_LOSS_BIT      1
`define RCF_FLG_RESET_VAL     8'h02
`define RCF_FLG_READ_MASK     8'h3A

// Control register fields (stop and counter reset).
`define RCF_CTL_HALT_BIT      1
`define RCF_CTL_CLEAR_BIT     0
`define RCF_CTL_RESET_VAL     8'h00

// Divider: a 4096 Hz tick from 250 MHz, 12 binary stages to 1 Hz.
`define RCF_CLK_HZ            250000000
`define RCF_BASE_HZ           4096
`define RCF_BASE_CYCLES       (`RCF_CLK_HZ / `RCF_BASE_HZ)
`define RCF_DIV_STAGES        12
`define RCF_TAP_64HZ          5

`endif

// >>> design/rcf_pkg.sv
package rcf_pkg;

    typedef enum logic [1:0] {
        RCF_SRC_4096HZ,
        RCF_SRC_64HZ,
        RCF_SRC_SECOND,
        RCF_SRC_MINUTE
    } rcf_src_t;

    typedef enum logic {
        RCF_ALARM_WEEKDAY,
        RCF_ALARM_DATE
    } rcf_alarm_t;

endpackage

// >>> design/rcf_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

module rcf_prescale
    import rcf_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // Control.
    input  wire logic hold_i,
    // Ticks.
    output logic      tick_4096_o,
    output logic      tick_64_o,
    output logic      tick_1_o
);

    logic [17:0]                   base_reg;
    logic [`RCF_DIV_STAGES-1:0]    div_reg;
    logic                          base_tick;

    assign base_tick = (base_reg == 18'(`RCF_BASE_CYCLES - 1));

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            base_reg <= 18'h00000;
        end else if (base_tick) begin
            base_reg <= 18'h00000;
        end else begin
            base_reg <= base_reg + 18'h00001;
        end
    end

    // Stages from 2048 Hz down to 1 Hz are held cleared while hold_i is high.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_reg <= '0;
        end else if (hold_i) begin
            div_reg <= '0;
        end else if (base_tick) begin
            div_reg <= div_reg + 12'h001;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tick_4096_o <= 1'b0;
            tick_64_o   <= 1'b0;
            tick_1_o    <= 1'b0;
        end else begin
            tick_4096_o <= base_tick;
            tick_64_o   <= base_tick && !hold_i && (&div_reg[`RCF_TAP_64HZ:0]);
            tick_1_o    <= base_tick && !hold_i && (&div_reg);
        end
    end

endmodule
`default_nettype wire

// >>> design/rcf_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

module rcf_top
    import rcf_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // Register port from the serial protocol engine.
    input  wire logic       reg_wr_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Bus conditions from the serial protocol engine.
    input  wire logic       bus_stop_i,
    input  wire logic       bus_restart_i,
    input  wire logic       bus_timeout_i,
    input  wire logic       timeout_active_i,
    // Event strobes from the counter, alarm and countdown blocks.
    input  wire logic       minute_carry_i,
    input  wire logic       alarm_match_i,
    input  wire logic       countdown_done_i,
    input  wire logic       data_loss_i,
    // Controls to the neighbouring blocks.
    output logic            count_run_o,
    output logic            second_tick_o,
    output logic            countdown_tick_o,
    output logic            countdown_load_o,
    output logic            countdown_run_o,
    output logic            alarm_date_o,
    output logic            update_event_o,
    output logic            test_mode_o
);

    logic [7:0] opt_reg;
    logic [7:0] flag_reg;
    logic       halt_reg;
    logic       clear_reg;
    logic       upd_flag_reg;
    logic       cnt_flag_reg;
    logic       alm_flag_reg;
    logic       loss_flag_reg;
    logic       loss_sync_reg;
    logic       loss_meta_reg;
    logic       tick_4096;
    logic       tick_64;
    logic       tick_1;
    logic       wr_opt;
    logic       wr_flg;
    logic       wr_ctl;
    logic       bus_event;
    logic       stopped;
    logic       sec_evt;
    logic       upd_evt;
    logic       alm_evt;
    logic       src_tick;
    rcf_src_t   src;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
        hit = reg_wr_i && (a == want);
    endfunction

    assign wr_opt    = hit(reg_addr_i, `RCF_ADDR_OPTIONS);
    assign wr_flg    = hit(reg_addr_i, `RCF_ADDR_FLAGS);
    assign wr_ctl    = hit(reg_addr_i, `RCF_ADDR_CONTROL);
    assign bus_event = bus_stop_i || bus_restart_i;
    assign stopped   = halt_reg || clear_reg;
    assign src       = rcf_src_t'({opt_reg[`RCF_OPT_SRC_HI_BIT], opt_reg[`RCF_OPT_SRC_LO_BIT]});

    rcf_prescale u_prescale (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .hold_i      (clear_reg),
        .tick_4096_o (tick_4096),
        .tick_64_o   (tick_64),
        .tick_1_o    (tick_1)
    );

    // Second and alarm events vanish while counting is stopped.
    assign sec_evt = tick_1 && !stopped;
    assign alm_evt = alarm_match_i && !stopped;
    assign upd_evt = opt_reg[`RCF_OPT_UPD_SEL_BIT] ? (minute_carry_i && !stopped)
                                                   : sec_evt;

    // Only the 4096 Hz source keeps running while counting is stopped.
    always_comb begin
        unique case (src)
            RCF_SRC_4096HZ: src_tick = tick_4096;
            RCF_SRC_64HZ:   src_tick = tick_64 && !stopped;
            RCF_SRC_SECOND: src_tick = sec_evt;
            RCF_SRC_MINUTE: src_tick = minute_carry_i && !stopped;
        endcase
    end

    // Stop and counter-reset control bits.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            halt_reg  <= 1'(`RCF_CTL_RESET_VAL >> `RCF_CTL_HALT_BIT);
            clear_reg <= 1'b0;
        end else begin
            if (wr_ctl) begin
                halt_reg <= reg_wdata_i[`RCF_CTL_HALT_BIT];
            end
            if (timeout_active_i && bus_event) begin
                clear_reg <= 1'b0;
            end else if (wr_ctl) begin
                clear_reg <= reg_wdata_i[`RCF_CTL_CLEAR_BIT];
            end
        end
    end

    // Option register with test-bit safety clear.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opt_reg <= `RCF_OPT_RESET_VAL;
        end else begin
            if (wr_opt) begin
                opt_reg <= reg_wdata_i & `RCF_OPT_RW_MASK;
            end
            if (bus_event || bus_timeout_i) begin
                opt_reg[`RCF_OPT_TEST_BIT] <= 1'b0;
            end
        end
    end

    // Data-loss input is asynchronous to the clock.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loss_meta_reg <= 1'b0;
            loss_sync_reg <= 1'b0;
        end else begin
            loss_meta_reg <= data_loss_i;
            loss_sync_reg <= loss_meta_reg;
        end
    end

    // Sticky flags: an event in the clearing cycle wins.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            upd_flag_reg  <= 1'b0;
            cnt_flag_reg  <= 1'b0;
            alm_flag_reg  <= 1'b0;
            loss_flag_reg <= 1'b1;
        end else begin
            if (upd_evt) begin
                upd_flag_reg <= 1'b1;
            end else if (wr_flg && !reg_wdata_i[`RCF_FLG_UPDATE_BIT]) begin
                upd_flag_reg <= 1'b0;
            end
            if (countdown_done_i) begin
                cnt_flag_reg <= 1'b1;
            end else if (wr_flg && !reg_wdata_i[`RCF_FLG_TIMER_BIT]) begin
                cnt_flag_reg <= 1'b0;
            end
            if (alm_evt) begin
                alm_flag_reg <= 1'b1;
            end else if (wr_flg && !reg_wdata_i[`RCF_FLG_ALARM_BIT]) begin
                alm_flag_reg <= 1'b0;
            end
            if (loss_sync_reg) begin
                loss_flag_reg <= 1'b1;
            end else if (wr_flg && !reg_wdata_i[`RCF_FLG_LOSS_BIT]) begin
                loss_flag_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        flag_reg = 8'h00;
        flag_reg[`RCF_FLG_UPDATE_BIT] = upd_flag_reg;
        flag_reg[`RCF_FLG_TIMER_BIT]  = cnt_flag_reg;
        flag_reg[`RCF_FLG_ALARM_BIT]  = alm_flag_reg;
        flag_reg[`RCF_FLG_LOSS_BIT]   = loss_flag_reg;
    end

    // Registered read data and outputs.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            unique case (reg_addr_i)
                `RCF_ADDR_OPTIONS: reg_rdata_o <= opt_reg;
                `RCF_ADDR_FLAGS:   reg_rdata_o <= flag_reg;
                `RCF_ADDR_CONTROL: reg_rdata_o <= {6'h00, halt_reg, clear_reg};
                default:           reg_rdata_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_run_o      <= 1'b0;
            second_tick_o    <= 1'b0;
            countdown_tick_o <= 1'b0;
            countdown_load_o <= 1'b0;
            countdown_run_o  <= 1'b0;
            alarm_date_o     <= 1'b0;
            update_event_o   <= 1'b0;
            test_mode_o      <= 1'b0;
        end else begin
            count_run_o      <= !stopped;
            second_tick_o    <= sec_evt;
            countdown_tick_o <= src_tick && opt_reg[`RCF_OPT_CNT_EN_BIT];
            countdown_load_o <= wr_opt && reg_wdata_i[`RCF_OPT_CNT_EN_BIT];
            countdown_run_o  <= opt_reg[`RCF_OPT_CNT_EN_BIT];
            alarm_date_o     <= opt_reg[`RCF_OPT_ALARM_SEL_BIT];
            update_event_o   <= upd_evt;
            test_mode_o      <= opt_reg[`RCF_OPT_TEST_BIT];
        end
    end

    // Checks.
    a_clear_cancel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        timeout_active_i && bus_event |=> !clear_reg)
        else $error("Counter reset not cancelled by bus condition.");
    a_test_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        bus_timeout_i |=> !opt_reg[`RCF_OPT_TEST_BIT])
        else $error("Test bit survived bus timeout.");
    a_frozen_tick: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        stopped |-> ##1 !second_tick_o)
        else $error("Second tick while stopped.");
    a_upd_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        upd_flag_reg && !(wr_flg && !reg_wdata_i[`RCF_FLG_UPDATE_BIT]) |=> upd_flag_reg)
        else $error("Update flag lost without a clear.");
    a_cnt_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        countdown_done_i |=> cnt_flag_reg)
        else $error("Timer flag not set.");
    a_alm_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        alm_evt |=> flag_reg[`RCF_FLG_ALARM_BIT])
        else $error("Alarm flag not set.");
    a_loss_write1: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_flg && reg_wdata_i[`RCF_FLG_LOSS_BIT] && loss_flag_reg |=> loss_flag_reg)
        else $error("Writing one changed the data-loss flag.");
    a_flag_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (flag_reg & ~`RCF_FLG_READ_MASK) == 8'h00)
        else $error("Reserved flag bit reads nonzero.");
    a_opt_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        opt_reg[3:2] == 2'b00)
        else $error("Reserved option bits nonzero.");
    a_src_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        clear_reg && src == RCF_SRC_64HZ |-> !src_tick)
        else $error("Timer source ran during counter reset.");

endmodule
`default_nettype wire

// >>> tb/rcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

module rcf_host_model (
    // Clock and read data from the block.
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    // Register port towards the block.
    output var  logic       wr_o,
    output var  logic [3:0] addr_o,
    output var  logic [7:0] wdata_o
);
    logic test_ok;

    initial begin
        wr_o = 1'b0;
        addr_o = 4'h0;
        wdata_o = 8'h00;
        test_ok = 1'b0;
    end

    // Writes one byte; the test bit is kept at 0 unless a scenario allows it.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = (a == `RCF_ADDR_OPTIONS && !test_ok) ? (d & 8'h7F) : d;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask

    // Reads one byte one cycle after the address is presented.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask
endmodule

`default_nettype wire

// >>> tb/rcf_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcf_map.svh"

module rcf_top_test;
    import rcf_pkg::*;

    logic       clk_i;
    logic       arst_n_i;
    logic       reg_wr;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [5:0] ev;
    logic       tmo_act;
    logic       loss;
    logic       count_run, sec_tick, cd_tick, cd_load, cd_run, alarm_date, upd_ev, test_mode;
    int         mismatches = 0;
    int         total_checks = 0;
    int         upd_cnt = 0;
    int         load_cnt = 0;
    int         tick_cnt = 0;

    rcf_host_model host (.clk_i(clk_i), .rdata_i(reg_rdata), .wr_o(reg_wr),
        .addr_o(reg_addr), .wdata_o(reg_wdata));

    rcf_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .bus_stop_i(ev[0]), .bus_restart_i(ev[1]), .bus_timeout_i(ev[2]),
        .timeout_active_i(tmo_act), .minute_carry_i(ev[3]), .alarm_match_i(ev[4]),
        .countdown_done_i(ev[5]), .data_loss_i(loss), .count_run_o(count_run),
        .second_tick_o(sec_tick), .countdown_tick_o(cd_tick),
        .countdown_load_o(cd_load), .countdown_run_o(cd_run),
        .alarm_date_o(alarm_date), .update_event_o(upd_ev), .test_mode_o(test_mode));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Pulse outputs are counted so that no one-cycle strobe is missed.
    always @(posedge clk_i) begin
        if (upd_ev === 1'b1) upd_cnt <= upd_cnt + 1;
        if (cd_load === 1'b1) load_cnt <= load_cnt + 1;
        if (cd_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic strobe(input int k);
        @(posedge clk_i);
        #1;
        ev[k] = 1'b1;
        @(posedge clk_i);
        #1;
        ev[k] = 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        check(name, d, exp);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #(4 * 150000);
        mismatches++;
        results();
    end

    initial begin
        int u;
        int i;
        arst_n_i = 1'b0;
        ev = 6'h00;
        tmo_act = 1'b0;
        loss = 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        rdchk("flags reset", `RCF_ADDR_FLAGS, 8'h02);
        rdchk("options reset", `RCF_ADDR_OPTIONS, 8'h00);
        rdchk("control reset", `RCF_ADDR_CONTROL, 8'h00);
        rdchk("unmapped", 4'h3, 8'h00);
        check("run after reset", {7'h00, count_run}, 8'h01);
        host.wr(`RCF_ADDR_FLAGS, 8'hFF);
        rdchk("flags write ones", `RCF_ADDR_FLAGS, 8'h02);
        host.wr(`RCF_ADDR_FLAGS, 8'h00);
        rdchk("loss cleared", `RCF_ADDR_FLAGS, 8'h00);
        strobe(4);
        rdchk("alarm flag", `RCF_ADDR_FLAGS, 8'h08);
        strobe(5);
        rdchk("timer flag", `RCF_ADDR_FLAGS, 8'h18);
        u = upd_cnt;
        strobe(3);
        repeat (2) @(posedge clk_i);
        check("no minute event on second mode", 8'(upd_cnt - u), 8'h00);
        host.wr(`RCF_ADDR_OPTIONS, 8'h20);
        strobe(3);
        repeat (2) @(posedge clk_i);
        check("minute event", 8'(upd_cnt - u), 8'h01);
        rdchk("update flag", `RCF_ADDR_FLAGS, 8'h38);
        host.wr(`RCF_ADDR_FLAGS, 8'hFF);
        rdchk("flags kept on ones", `RCF_ADDR_FLAGS, 8'h38);
        @(posedge clk_i);
        #1;
        loss = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        loss = 1'b0;
        repeat (4) @(posedge clk_i);
        rdchk("loss flag", `RCF_ADDR_FLAGS, 8'h3A);
        host.wr(`RCF_ADDR_FLAGS, 8'h00);
        rdchk("all cleared", `RCF_ADDR_FLAGS, 8'h00);
        host.wr(`RCF_ADDR_OPTIONS, 8'h7F);
        rdchk("options fields", `RCF_ADDR_OPTIONS, 8'h73);
        check("date target", {7'h00, alarm_date}, 8'h01);
        check("enable level", {7'h00, cd_run}, 8'h01);
        check("load pulse", 8'(load_cnt), 8'h01);
        host.wr(`RCF_ADDR_OPTIONS, 8'h00);
        rdchk("options low", `RCF_ADDR_OPTIONS, 8'h00);
        check("weekday target", {7'h00, alarm_date}, 8'h00);
        check("timer stopped", {7'h00, cd_run}, 8'h00);
        host.test_ok = 1'b1;
        for (i = 0; i < 3; i++) begin
            host.wr(`RCF_ADDR_OPTIONS, 8'h80);
            repeat (2) @(posedge clk_i);
            check("test set", {7'h00, test_mode}, 8'h01);
            strobe(i);
            repeat (2) @(posedge clk_i);
            check("test cleared", {7'h00, test_mode}, 8'h00);
            rdchk("test bit read", `RCF_ADDR_OPTIONS, 8'h00);
        end
        host.test_ok = 1'b0;
        host.wr(`RCF_ADDR_OPTIONS, 8'h20);
        host.wr(`RCF_ADDR_CONTROL, 8'h01);
        repeat (3) @(posedge clk_i);
        check("halted by clear", {7'h00, count_run}, 8'h00);
        u = upd_cnt;
        strobe(4);
        strobe(3);
        repeat (2) @(posedge clk_i);
        rdchk("no events while held", `RCF_ADDR_FLAGS, 8'h00);
        check("no update pulse", 8'(upd_cnt - u), 8'h00);
        strobe(0);
        rdchk("clear kept", `RCF_ADDR_CONTROL, 8'h01);
        host.wr(`RCF_ADDR_OPTIONS, 8'h10);
        tmo_act = 1'b1;
        for (i = 0; i < 61200 && tick_cnt == 0; i++) @(posedge clk_i);
        check("fast tick while held", 8'(tick_cnt != 0), 8'h01);
        strobe(1);
        rdchk("restart clears", `RCF_ADDR_CONTROL, 8'h00);
        host.wr(`RCF_ADDR_CONTROL, 8'h01);
        strobe(0);
        rdchk("stop clears", `RCF_ADDR_CONTROL, 8'h00);
        tmo_act = 1'b0;
        host.wr(`RCF_ADDR_CONTROL, 8'h03);
        host.wr(`RCF_ADDR_CONTROL, 8'h02);
        repeat (3) @(posedge clk_i);
        check("stop alone holds", {7'h00, count_run}, 8'h00);
        host.wr(`RCF_ADDR_CONTROL, 8'h00);
        repeat (3) @(posedge clk_i);
        check("both clear runs", {7'h00, count_run}, 8'h01);
        results();
    end
endmodule

`default_nettype wire
